// ===== inc/shc_regs.vh
/*
  Constants for the card host control block: byte addresses, field
  positions, reset values and timing counts.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef SHC_REGS_VH
`define SHC_REGS_VH

// Register byte addresses on the AXI4-Lite bus
`define SHC_CTRL_ADDR 32'h5A000000
`define SHC_PRE_ADDR 32'h5A000004
`define SHC_DATA_ADDR 32'h5A000040
`define SHC_DSTAT_ADDR 32'h5A000044
`define SHC_ISTAT_ADDR 32'h5A000048
`define SHC_IMASK_ADDR 32'h5A00004C

// Address decode codes
`define SHC_SEL_NONE 3'h0
`define SHC_SEL_CTRL 3'h1
`define SHC_SEL_PRE 3'h2
`define SHC_SEL_DATA 3'h3
`define SHC_SEL_DSTAT 3'h4
`define SHC_SEL_ISTAT 3'h5
`define SHC_SEL_IMASK 3'h6

// Control register fields
`define SHC_B_SRST 8
`define SHC_B_CSTYLE 5
`define SHC_B_BORD 4
`define SHC_B_IRQEN 3
`define SHC_B_RWEN 2
`define SHC_B_CKEN 0
`define SHC_CTRL_MASK 32'h0000003D

// Reset values
`define SHC_CTRL_RST 32'h00000000
`define SHC_PRE_RST 8'h01
`define SHC_STAT_RST 2'h0

// Event bits of the status and mask registers
`define SHC_EV_CARD_IRQ 0
`define SHC_EV_RW_START 1

// Data status: read-wait stop bit
`define SHC_B_RW_STOP 0

// Read-wait request starts this many card clocks after a block ends
`define SHC_RW_DELAY 2'd2

// Write strobe pattern that marks a halfword access
`define SHC_HALF_STRB 4'h3

// AXI responses
`define SHC_RESP_OKAY 2'h0
`define SHC_RESP_SLVERR 2'h2

`endif

// ===== hdl/shc_top.v
/*
  Card host control register bank with AXI4-Lite slave, card clock
  divider, FIFO byte-order serializer, card interrupt detect on data
  line 1 and read-wait request on data line 2.
  Assumes the data path supplies block-end, multi-block-read, wide-bus
  and interrupt-period signals on CLK; data line 1 is an async pin.
*/
// How it works
// - Soft reset bit pulses block reset, self-clears
// - Clock style bit picks SD or MMC clocking
// - Byte order bit picks FIFO byte order
// - Order A sends low byte first
// - Order B sends high byte first
// - Card interrupt detect only when enabled
// - Read-wait request only when enabled
// - Clock enable starts divider and clock output
// - Card clock equals bus clock over prescaler+1
// - Read-wait starts two card clocks after block
// - Wide bus samples interrupt only in period
`timescale 1ns/1ps
`default_nettype none
`include "shc_regs.vh"

module shc_top (
  input wire CLK,
  input wire RESET,
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire BLOCK_END,
  input wire MULTI_READ,
  input wire WIDE_BUS,
  input wire IRQ_PERIOD,
  input wire DATA_LINE1_IN,
  output reg DATA_LINE2_OUT,
  output reg DATA_LINE2_OE_N,
  output reg CARD_CLOCK,
  output reg CARD_LAUNCH,
  output reg [7:0] FIFO_BYTE,
  output reg FIFO_BYTE_VALID,
  output reg BLOCK_SOFT_RESET,
  output reg IRQ
);

  // Read-wait states, one-hot
  localparam RW_IDLE = 3'b001;
  localparam RW_COUNT = 3'b010;
  localparam RW_DRIVE = 3'b100;

  // Software-visible state
  reg [31:0] ctrl_r; // Control register, reserved bits held zero
  reg [7:0] pre_r; // Card clock divider setting
  reg [1:0] istat_r; // Sticky event bits
  reg [1:0] imask_r; // Event mask
  reg stop_r; // Read-wait stop bit
  reg srst_r; // One-cycle block reset pulse
  // Write channel holding
  reg aw_full_r;
  reg [31:0] awaddr_r;
  reg w_full_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  // Divider
  reg [7:0] div_cnt_r;
  reg card_rise_r; // Card clock rising-edge pulse
  reg card_fall_r; // Card clock falling-edge pulse
  // Byte serializer
  reg [31:0] tx_shift_r;
  reg [2:0] tx_left_r; // Bytes still to send
  // Data line 1 synchroniser
  reg dat1_meta_r;
  reg dat1_sync_r;
  // Read-wait machine
  reg [2:0] rw_state_r;
  reg [1:0] rw_cnt_r;

  // Maps a byte address onto a register select code
  function [2:0] reg_sel;
    input [31:0] addr;
    begin
      case (addr)
        `SHC_CTRL_ADDR: reg_sel = `SHC_SEL_CTRL;
        `SHC_PRE_ADDR: reg_sel = `SHC_SEL_PRE;
        `SHC_DATA_ADDR: reg_sel = `SHC_SEL_DATA;
        `SHC_DSTAT_ADDR: reg_sel = `SHC_SEL_DSTAT;
        `SHC_ISTAT_ADDR: reg_sel = `SHC_SEL_ISTAT;
        `SHC_IMASK_ADDR: reg_sel = `SHC_SEL_IMASK;
        default: reg_sel = `SHC_SEL_NONE;
      endcase
    end
  endfunction

  // Decoded write target and execute condition
  wire [2:0] wsel = reg_sel(awaddr_r);
  wire tx_busy = (tx_left_r != 3'd0);
  // Data port writes wait for the serializer, stalling the response
  wire wr_go = aw_full_r && w_full_r && !S_AXI_BVALID &&
               !(wsel == `SHC_SEL_DATA && tx_busy);
  wire ctrl_wr = wr_go && (wsel == `SHC_SEL_CTRL);
  wire pre_wr = wr_go && (wsel == `SHC_SEL_PRE);
  wire data_wr = wr_go && (wsel == `SHC_SEL_DATA);
  wire dstat_wr = wr_go && (wsel == `SHC_SEL_DSTAT);
  wire istat_wr = wr_go && (wsel == `SHC_SEL_ISTAT);
  wire imask_wr = wr_go && (wsel == `SHC_SEL_IMASK);
  wire half_acc = (wstrb_r == `SHC_HALF_STRB);

  // Events raised this cycle
  wire ev_card_irq;
  wire ev_rw_start;
  wire [1:0] ev_set = {ev_rw_start, ev_card_irq};
  wire [1:0] ev_clr = istat_wr ? wdata_r[1:0] : 2'h0;
  // Set wins over a clear in the same cycle
  wire [1:0] istat_nxt = (istat_r & ~ev_clr) | ev_set;

  // Write address/data capture, in either order
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_full_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      w_full_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `SHC_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        // Unmapped address gets an error, nothing stored
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wsel == `SHC_SEL_NONE) ? `SHC_RESP_SLVERR :
                       `SHC_RESP_OKAY;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        // Next write only after the response is taken
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `SHC_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= `SHC_RESP_OKAY;
      case (reg_sel(S_AXI_ARADDR))
        // Soft reset bit and reserved bits always read zero
        `SHC_SEL_CTRL: S_AXI_RDATA <= ctrl_r & `SHC_CTRL_MASK;
        `SHC_SEL_PRE: S_AXI_RDATA <= {24'h000000, pre_r};
        `SHC_SEL_DATA: S_AXI_RDATA <= 32'h00000000;
        `SHC_SEL_DSTAT: S_AXI_RDATA <= {31'h00000000, stop_r};
        `SHC_SEL_ISTAT: S_AXI_RDATA <= {30'h00000000, istat_r};
        `SHC_SEL_IMASK: S_AXI_RDATA <= {30'h00000000, imask_r};
        default: begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `SHC_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Software registers; soft reset returns them to reset values
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_r <= `SHC_CTRL_RST;
      pre_r <= `SHC_PRE_RST;
      istat_r <= `SHC_STAT_RST;
      imask_r <= `SHC_STAT_RST;
      srst_r <= 1'b0;
    end else if (srst_r) begin
      // Pulse lasts one cycle, so the block runs again next cycle
      ctrl_r <= `SHC_CTRL_RST;
      pre_r <= `SHC_PRE_RST;
      istat_r <= `SHC_STAT_RST;
      imask_r <= `SHC_STAT_RST;
      srst_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        // Reserved and soft reset positions never stored
        ctrl_r <= wdata_r & `SHC_CTRL_MASK;
        srst_r <= wdata_r[`SHC_B_SRST];
      end
      if (pre_wr) begin
        pre_r <= wdata_r[7:0];
      end
      if (imask_wr) begin
        imask_r <= wdata_r[1:0];
      end
      istat_r <= istat_nxt;
    end
  end

  // Card clock divider: period of prescaler+1 bus clocks
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_cnt_r <= 8'h00;
      CARD_CLOCK <= 1'b0;
      card_rise_r <= 1'b0;
      card_fall_r <= 1'b0;
    end else if (srst_r || !ctrl_r[`SHC_B_CKEN]) begin
      // Prescaler off, clock parked low
      div_cnt_r <= 8'h00;
      CARD_CLOCK <= 1'b0;
      card_rise_r <= 1'b0;
      card_fall_r <= 1'b0;
    end else if (div_cnt_r == pre_r) begin
      // Wrap gives a rising edge; prescaler zero is illegal
      div_cnt_r <= 8'h00;
      CARD_CLOCK <= 1'b1;
      card_rise_r <= 1'b1;
      card_fall_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      card_rise_r <= 1'b0;
      // High for the first half of the period
      if (div_cnt_r == {1'b0, pre_r[7:1]}) begin
        CARD_CLOCK <= 1'b0;
        card_fall_r <= 1'b1;
      end else begin
        card_fall_r <= 1'b0;
      end
    end
  end

  // Launch strobe: SD style on falling edges, MMC style on rising
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CARD_LAUNCH <= 1'b0;
    end else if (ctrl_r[`SHC_B_CSTYLE]) begin
      CARD_LAUNCH <= card_rise_r;
    end else begin
      CARD_LAUNCH <= card_fall_r;
    end
  end

  // Byte serializer for data port writes, byte 0 of shift first
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tx_shift_r <= 32'h00000000;
      tx_left_r <= 3'd0;
      FIFO_BYTE <= 8'h00;
      FIFO_BYTE_VALID <= 1'b0;
    end else if (srst_r) begin
      tx_shift_r <= 32'h00000000;
      tx_left_r <= 3'd0;
      FIFO_BYTE <= 8'h00;
      FIFO_BYTE_VALID <= 1'b0;
    end else if (data_wr) begin
      FIFO_BYTE_VALID <= 1'b0;
      tx_left_r <= half_acc ? 3'd2 : 3'd4;
      if (!ctrl_r[`SHC_B_BORD]) begin
        // Order A keeps the natural lane order
        tx_shift_r <= half_acc ? {16'h0000, wdata_r[15:0]} :
                      wdata_r;
      end else if (half_acc) begin
        // Order B halfword: upper byte first
        tx_shift_r <= {16'h0000, wdata_r[7:0], wdata_r[15:8]};
      end else begin
        // Order B word: byte 3 first
        tx_shift_r <= {wdata_r[7:0], wdata_r[15:8],
                       wdata_r[23:16], wdata_r[31:24]};
      end
    end else if (tx_busy) begin
      FIFO_BYTE <= tx_shift_r[7:0];
      FIFO_BYTE_VALID <= 1'b1;
      tx_shift_r <= {8'h00, tx_shift_r[31:8]};
      tx_left_r <= tx_left_r - 3'd1;
    end else begin
      FIFO_BYTE_VALID <= 1'b0;
    end
  end

  // Two-stage synchroniser for the card's data line 1
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dat1_meta_r <= 1'b1;
      dat1_sync_r <= 1'b1;
    end else begin
      dat1_meta_r <= DATA_LINE1_IN;
      dat1_sync_r <= dat1_meta_r;
    end
  end

  // Card pulls line 1 low to interrupt; wide bus shares the line
  assign ev_card_irq = ctrl_r[`SHC_B_IRQEN] && !srst_r &&
                       !dat1_sync_r &&
                       (!WIDE_BUS || IRQ_PERIOD);

  // Read-wait request enters drive after its delay
  assign ev_rw_start = (rw_state_r == RW_COUNT) && card_rise_r &&
                       (rw_cnt_r == `SHC_RW_DELAY - 2'd1) &&
                       ctrl_r[`SHC_B_RWEN];

  // Stop bit: software sets it, hardware clears it per new wait
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stop_r <= 1'b0;
    end else if (srst_r) begin
      stop_r <= 1'b0;
    end else if (dstat_wr && wdata_r[`SHC_B_RW_STOP]) begin
      // A write of one wins over the hardware clear
      stop_r <= 1'b1;
    end else if (rw_state_r == RW_IDLE && BLOCK_END) begin
      stop_r <= 1'b0;
    end
  end

  // Read-wait machine between blocks of a multiple-block read
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rw_state_r <= RW_IDLE;
      rw_cnt_r <= 2'd0;
    end else if (srst_r || !ctrl_r[`SHC_B_RWEN]) begin
      // Disabled: no request, any pending one dropped
      rw_state_r <= RW_IDLE;
      rw_cnt_r <= 2'd0;
    end else begin
      case (rw_state_r)
        RW_IDLE: begin
          // Wait for the end of a block in a multi-block read
          if (BLOCK_END && MULTI_READ) begin
            rw_state_r <= RW_COUNT;
            rw_cnt_r <= 2'd0;
          end
        end
        RW_COUNT: begin
          // Count card clock rising edges; a stopped clock waits
          if (ev_rw_start) begin
            rw_state_r <= RW_DRIVE;
          end else if (card_rise_r) begin
            rw_cnt_r <= rw_cnt_r + 2'd1;
          end
        end
        RW_DRIVE: begin
          // Holds until software sets the stop bit
          if (stop_r) begin
            rw_state_r <= RW_IDLE;
          end
        end
        default: begin
          rw_state_r <= RW_IDLE;
        end
      endcase
    end
  end

  // Line 2 drive: low request, enable active low while driving
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      DATA_LINE2_OUT <= 1'b1;
      DATA_LINE2_OE_N <= 1'b1;
    end else begin
      DATA_LINE2_OUT <= 1'b0;
      DATA_LINE2_OE_N <= !(rw_state_r == RW_DRIVE && !stop_r);
    end
  end

  // Block reset and interrupt outputs, registered
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      BLOCK_SOFT_RESET <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      BLOCK_SOFT_RESET <= srst_r;
      IRQ <= |(istat_r & imask_r);
    end
  end

endmodule
`default_nettype wire

// ===== bench/shc_sva.sv
/* Port checker for the card host control block.
   Assumes one clock, RESET async high, AXI4-Lite master on the bus. */
`timescale 1ns/1ps
`default_nettype none
`include "shc_regs.vh"
module shc_sva (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic DATA_LINE2_OUT,
  input wire logic DATA_LINE2_OE_N,
  input wire logic CARD_CLOCK,
  input wire logic BLOCK_SOFT_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [31:0] aw_r, w_r, ar_r; // Last accepted addresses and data
  logic ck_r, rw_r; // Mirrors of clock and read-wait enables
  // Mirror enables from completed control writes; bit 8 clears all
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_r <= 32'h0;
      w_r <= 32'h0;
      ar_r <= 32'h0;
      ck_r <= 1'h0;
      rw_r <= 1'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_r <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) w_r <= S_AXI_WDATA;
      if (S_AXI_ARVALID && S_AXI_ARREADY) ar_r <= S_AXI_ARADDR;
      if (S_AXI_BVALID && S_AXI_BREADY && aw_r == `SHC_CTRL_ADDR) begin
        ck_r <= w_r[0] && !w_r[8];
        rw_r <= w_r[2] && !w_r[8];
      end
    end
  end
  property p_srst_pulse;
    BLOCK_SOFT_RESET |=> !BLOCK_SOFT_RESET;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse)
    else $error("soft reset pulse too long");
  property p_srst_cause;
    BLOCK_SOFT_RESET |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2);
  endproperty
  a_srst_cause: assert property (p_srst_cause)
    else $error("soft reset without a write");
  property p_ck_off;
    !ck_r [*4] |-> !CARD_CLOCK;
  endproperty
  a_ck_off: assert property (p_ck_off)
    else $error("card clock runs while disabled");
  property p_rw_off;
    !rw_r [*4] |-> DATA_LINE2_OE_N;
  endproperty
  a_rw_off: assert property (p_rw_off)
    else $error("read wait driven while disabled");
  property p_rw_low;
    !DATA_LINE2_OE_N |-> !DATA_LINE2_OUT;
  endproperty
  a_rw_low: assert property (p_rw_low)
    else $error("read wait level not low");
  property p_ctrl_rsv;
    S_AXI_RVALID && ar_r == `SHC_CTRL_ADDR |-> (S_AXI_RDATA & ~32'h3D) == 0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv)
    else $error("reserved control bits not zero");
  property p_rd_lat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_wr_busy;
    S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY;
  endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("second write taken early");
endmodule
bind shc_top shc_sva u_sva (.CLK(CLK), .RESET(RESET),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .DATA_LINE2_OUT(DATA_LINE2_OUT), .DATA_LINE2_OE_N(DATA_LINE2_OE_N),
  .CARD_CLOCK(CARD_CLOCK), .BLOCK_SOFT_RESET(BLOCK_SOFT_RESET));
`default_nettype wire

// ===== bench/shc_card.sv
/* Behavioural card on data lines 1 and 2.
   Assumes both lines carry pull-ups and the host makes the card clock. */
`timescale 1ns/1ps
`default_nettype none
module shc_card (
  input wire logic card_clock,
  input wire logic line2_out,
  input wire logic line2_oe_n,
  output var logic line1
);
  int edges; // Card clock rising edges
  int held; // Edges seen while read wait holds line 2
  wire logic line2; // Pulled up when the host lets go
  assign line2 = line2_oe_n ? 1'h1 : line2_out;
  // Line 1 idles high through its pull-up
  initial begin
    line1 = 1'h1;
    edges = 0;
    held = 0;
  end
  // Card pauses data while line 2 is held low
  always @(posedge card_clock) begin
    edges <= edges + 1;
    if (!line2) held <= held + 1;
  end
  // Card signals an interrupt by pulling line 1 low
  task automatic signal_irq(input int cyc);
    // Non-blocking, so the pin never races the host's sampling edge
    line1 <= 1'h0;
    #(cyc * 25);
    line1 <= 1'h1;
  endtask
endmodule
`default_nettype wire

// ===== bench/shc_top_tb.sv
/* Self-checking bench for the card host control block.
   Assumes shc_top, the card model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
`include "shc_regs.vh"
module shc_top_tb;
  logic CLK, RESET, awv, wv, bre, arv, rre, blk, mr, wide, prd; // Drives
  logic [31:0] awa, wd, ara, rdat; // Bus payloads, last read data
  logic [3:0] ws; // Write strobes
  logic [1:0] rsp; // Last response
  wire logic awr, wrr, bv, arr, rv, l1, l2o, l2e, ck, lau, fv, srst, irq;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd_w;
  wire logic [7:0] fb;
  int error_cnt, tests_run, n, per, cyc, rises, sr_cnt, e0;
  logic ck_d, lau_ck; // Previous card clock, its level at launch
  logic [7:0] bq[$]; // Bytes seen on the FIFO side
  shc_top dut (.CLK(CLK), .RESET(RESET), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd_w), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .BLOCK_END(blk), .MULTI_READ(mr),
    .WIDE_BUS(wide), .IRQ_PERIOD(prd), .DATA_LINE1_IN(l1),
    .DATA_LINE2_OUT(l2o), .DATA_LINE2_OE_N(l2e), .CARD_CLOCK(ck),
    .CARD_LAUNCH(lau), .FIFO_BYTE(fb), .FIFO_BYTE_VALID(fv),
    .BLOCK_SOFT_RESET(srst), .IRQ(irq));
  shc_card card (.card_clock(ck), .line2_out(l2o), .line2_oe_n(l2e),
    .line1(l1));
  initial begin
    CLK = 1'h0;
    forever #12.5 CLK = ~CLK;
  end
  // Card clock period, launch level, soft reset pulses, FIFO bytes
  always @(posedge CLK) begin
    ck_d <= ck;
    cyc <= (ck && !ck_d) ? 1 : cyc + 1;
    if (ck && !ck_d) per <= cyc;
    if (ck && !ck_d) rises <= rises + 1;
    if (lau) lau_ck <= ck;
    if (srst) sr_cnt <= sr_cnt + 1;
    if (fv) bq.push_back(fb);
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A bounded wait that ran out ends the run
  task tmo;
    if (n >= 60) error_cnt++;
    if (n >= 60) final_report();
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hF);
    @(posedge CLK);
    {awa, wd, ws} <= {a, d, s};
    {awv, wv, bre} <= 3'h7;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
      if (awr) awv <= 1'h0;
      if (wrr) wv <= 1'h0;
    end while (!bv && n < 60);
    bre <= 1'h0;
    rsp = br;
    tmo();
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge CLK);
    ara <= a;
    {arv, rre} <= 2'h3;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
      if (arr) arv <= 1'h0;
    end while (!rv && n < 60);
    rre <= 1'h0;
    {rdat, rsp} = {rd_w, rr};
    tmo();
  endtask
  task t_regs;
    rd(`SHC_CTRL_ADDR);
    chk("ctrl reset", rdat, 32'h0);
    wr(`SHC_CTRL_ADDR, 32'hFFFFFEFF);
    rd(`SHC_CTRL_ADDR);
    chk("ctrl fields", rdat, 32'h3D);
    wr(32'h5A0000F0, 32'h1);
    chk("unmapped write", rsp, `SHC_RESP_SLVERR);
    rd(32'h5A0000F0);
    chk("unmapped read", rsp, `SHC_RESP_SLVERR);
  endtask
  task t_srst;
    wr(`SHC_PRE_ADDR, 32'h10);
    sr_cnt = 0;
    wr(`SHC_CTRL_ADDR, 32'h13D);
    repeat (4) @(posedge CLK);
    chk("soft reset pulses", sr_cnt, 1);
    rd(`SHC_CTRL_ADDR);
    chk("ctrl after soft reset", rdat, 32'h0);
    rd(`SHC_PRE_ADDR);
    chk("divider after soft reset", rdat, 32'h1);
  endtask
  task t_clk;
    wr(`SHC_PRE_ADDR, 32'h3);
    for (int st = 0; st < 2; st++) begin
      wr(`SHC_CTRL_ADDR, st ? 32'h21 : 32'h01);
      repeat (20) @(posedge CLK);
      chk("card clock period", per, 4);
      chk("launch edge", lau_ck, st);
    end
    wr(`SHC_CTRL_ADDR, 32'h0);
    repeat (4) @(posedge CLK);
    n = rises;
    repeat (20) @(posedge CLK);
    chk("clock stopped", rises - n, 0);
  endtask
  task t_bytes;
    for (int i = 0; i < 4; i++) begin
      wr(`SHC_CTRL_ADDR, i[1] ? 32'h10 : 32'h0);
      bq.delete();
      wr(`SHC_DATA_ADDR, 32'h44332211, i[0] ? `SHC_HALF_STRB : 4'hF);
      repeat (8) @(posedge CLK);
      n = i[0] ? 2 : 4;
      chk("byte count", bq.size(), n);
      for (int k = 0; k < bq.size(); k++)
        chk("fifo byte", bq[k], 8'h11 * (i[1] ? n - k : k + 1));
    end
  endtask
  // Rows: enable, mask, wide bus, period, status expected
  task t_irq;
    logic [4:0] tv[5] = '{5'b11001, 5'b10001, 5'b01000, 5'b11100, 5'b11111};
    for (int i = 0; i < 5; i++) begin
      wr(`SHC_CTRL_ADDR, {27'h0, tv[i][4], 3'h0});
      wr(`SHC_IMASK_ADDR, {31'h0, tv[i][3]});
      {wide, prd} <= tv[i][2:1];
      card.signal_irq(8);
      repeat (4) @(posedge CLK);
      chk("irq line", irq, tv[i][0] & tv[i][3]);
      rd(`SHC_ISTAT_ADDR);
      chk("irq status", rdat[0], tv[i][0]);
      wr(`SHC_ISTAT_ADDR, 32'h1);
      repeat (2) @(posedge CLK);
      chk("irq cleared", irq, 1'h0);
    end
  endtask
  task pulse_blk;
    @(posedge CLK);
    blk <= 1'h1;
    @(posedge CLK);
    blk <= 1'h0;
  endtask
  task t_rw;
    wr(`SHC_PRE_ADDR, 32'h1);
    wr(`SHC_CTRL_ADDR, 32'h5);
    mr <= 1'h1;
    pulse_blk();
    e0 = card.edges;
    n = 0;
    while (l2e && n < 60) begin
      @(posedge CLK);
      n++;
    end
    tmo();
    n = card.edges - e0;
    chk("read wait delay", n >= 2 && n <= 3, 1'h1);
    chk("read wait level", l2o, 1'h0);
    rd(`SHC_ISTAT_ADDR);
    chk("read wait event", rdat[1], 1'h1);
    wr(`SHC_DSTAT_ADDR, 32'h1);
    repeat (2) @(posedge CLK);
    chk("read wait ended", l2e, 1'h1);
    chk("card paused", card.held > 0, 1'h1);
    wr(`SHC_CTRL_ADDR, 32'h1);
    pulse_blk();
    n = 0;
    repeat (20) @(posedge CLK) n += !l2e;
    chk("read wait off", n, 0);
  endtask
  initial begin
    {RESET, awv, wv, bre, arv, rre, blk, mr, wide, prd} = 10'h200;
    {awa, wd, ara, ws} = 100'h0;
    {error_cnt, tests_run, per, cyc, rises, sr_cnt} = 0;
    repeat (4) @(posedge CLK);
    RESET <= 1'h0;
    t_regs();
    t_srst();
    t_clk();
    t_bytes();
    t_irq();
    t_rw();
    final_report();
  end
endmodule
`default_nettype wire
